// ---- core/adc_fmt_pkg.sv ----
// constants, field layout and types for the converter result formatting and status block
// Notes on behaviour
// - 8-bit left justified result sits on bits 15..8, signed or unsigned.
// - 10-bit left justified result sits on bits 15..6, signed or unsigned.
// - right justified is always unsigned: bits 7..0 or 9..0.
// - left justified signed is the unsigned code with its top bit inverted.
// - three-bit channel code is a plain binary index of inputs zero to seven.
// - sequence done flag (status bit 7) sets at each sequence end, also in scan.
// - sequence done clears on write one, start register write, or fast-clear result read.
// - edge trigger mode: extra trigger edge during a sequence sets trigger overrun (bit 5).
// - trigger overrun clears on write one, control two..four write, or start write.
// - result overrun (bit 4) sets when a result is written while its done flag is set.
// - result overrun clears on write one or any new sequence start.
// - status bits 2..0 hold the read-only conversion counter; status writes do not touch it.
// - non-FIFO mode: counter returns to zero at sequence start and end.
// - FIFO mode keeps the counter across trigger-started sequences; it always wraps seven to zero.
// - any write to control two..five clears the counter, even in FIFO mode.
// - test register reads undefined data; writable only in special mode.
// - signed results are two's complement and never right justified.
// - multi-channel mode advances the channel code per conversion, wrapping.
package adc_fmt_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int RAW_W = 10;
   localparam int RES_W = 16;
   localparam int IDX_W = 3;
   localparam int NUM_RES = 8;
   localparam logic [ADDR_W-1:0] OFS_CTRL_TWO = 5'h02;
   localparam logic [ADDR_W-1:0] OFS_CTRL_THREE = 5'h03;
   localparam logic [ADDR_W-1:0] OFS_CTRL_FOUR = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_SEQ_START = 5'h05;
   localparam logic [ADDR_W-1:0] OFS_STATUS_ZERO = 5'h06;
   localparam logic [ADDR_W-1:0] OFS_TEST_ZERO = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_DONE_FLAGS = 5'h0B;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h0D;
   localparam logic [ADDR_W-1:0] OFS_RESULT_BASE = 5'h10;
   localparam logic [ADDR_W-1:0] RESULT_MASK = 5'h10;
   localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
   localparam logic [IDX_W-1:0] IDX_ZERO = 3'h0;
   // control two
   localparam int B_FAST_CLR = 6;
   localparam int B_TRIG_LEVEL = 3;
   localparam int B_TRIG_EN = 2;
   // control three
   localparam int B_LEN_MSB = 5;
   localparam int B_LEN_LSB = 3;
   localparam int B_FIFO = 2;
   // control four
   localparam int B_RES8 = 7;
   // sequence start
   localparam int B_RJUST = 7;
   localparam int B_SIGNED = 6;
   localparam int B_SCAN = 5;
   localparam int B_MULTI_CHANNEL_SEL = 4;
   // status zero
   localparam int B_SCF = 7;
   localparam int B_TRIGGER_OVERRUN_FLAG = 5;
   localparam int B_RESULT_OVERRUN_FLAG = 4;
   // interrupt status and mask
   localparam int B_IRQ_SEQ = 0;
   localparam int B_IRQ_TRIG = 1;
   localparam int B_IRQ_OVR = 2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } seq_state_t;

   function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] v);
      return v + 3'h1;
   endfunction

   function automatic logic is_result(input logic [ADDR_W-1:0] a);
      return (a & RESULT_MASK) == OFS_RESULT_BASE;
   endfunction
endpackage

// ---- core/adc_result_format_status.sv ----
// converter sequencer: result formatting, status flags, conversion counter and registers
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
module adc_result_format_status
   import adc_fmt_pkg::*;
(
   input wire logic mclk_i, // module clock, 125 MHz
   input wire logic sys_rst_i, // synchronous reset, high
   input wire logic [4:0] addr_i, // register byte offset
   input wire logic [7:0] wdata_i, // write data
   input wire logic wr_i, // write strobe
   input wire logic rd_i, // read strobe
   output logic [7:0] rdata_o, // read data, cycle after rd_i
   input wire logic special_mode_i, // special operating mode
   input wire logic ext_trig_i, // external trigger level
   input wire logic conv_done_i, // core finished one conversion
   input wire logic [9:0] conv_data_i, // raw code of that conversion
   output logic conv_req_o, // sequence in progress
   output logic [2:0] channel_o, // analog input to convert
   output logic irq_o // unmasked event pending
);
   result_path_if rp ();

   result_formatter u_fmt (
      .rp(rp.fmt_side)
   );

   result_bank u_bank (
      .mclk_i(mclk_i),
      .sys_rst_i(sys_rst_i),
      .rp(rp.bank)
   );

   logic [DATA_W-1:0] ctrl2_reg, ctrl2_next;
   logic [DATA_W-1:0] ctrl3_reg, ctrl3_next;
   logic [DATA_W-1:0] ctrl4_reg, ctrl4_next;
   logic [DATA_W-1:0] ctrl5_reg, ctrl5_next;
   logic [DATA_W-1:0] test_reg, test_next;
   logic [DATA_W-1:0] mask_reg, mask_next;
   seq_state_t state_reg, state_next;
   logic [IDX_W-1:0] cc_reg, cc_next;
   logic [IDX_W-1:0] pos_reg, pos_next;
   logic [IDX_W-1:0] chan_reg, chan_next;
   logic trig_d_reg, trig_d_next;
   logic scf_reg, scf_next;
   logic trigger_overrun_flag_reg, trigger_overrun_flag_next;
   logic result_overrun_flag_reg, result_overrun_flag_next;
   logic armed_reg, armed_next;
   logic [DATA_W-1:0] irqs_reg, irqs_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;

   logic wr_ctrl5, wr_abort, wr_status, wr_irqs;
   logic res_rd, fast_clr, fifo_mode, running;
   logic trig_edge, trig_start, trig_ovr, start, conv_ok, seq_end;
   logic [IDX_W-1:0] last_pos, code;
   logic [DATA_W-1:0] status_val;

   // access decode
   always_comb begin
      wr_ctrl5 = wr_i && addr_i == OFS_SEQ_START;
      wr_abort = wr_i && (addr_i == OFS_CTRL_TWO || addr_i == OFS_CTRL_THREE
                          || addr_i == OFS_CTRL_FOUR);
      wr_status = wr_i && addr_i == OFS_STATUS_ZERO;
      wr_irqs = wr_i && addr_i == OFS_IRQ_STATUS;
      res_rd = rd_i && is_result(addr_i);
      fast_clr = ctrl2_reg[B_FAST_CLR];
      fifo_mode = ctrl3_reg[B_FIFO];
      running = state_reg == ST_RUN;
      last_pos = ctrl3_reg[B_LEN_MSB:B_LEN_LSB] - 3'h1;
      code = wr_ctrl5 ? wdata_i[IDX_W-1:0] : ctrl5_reg[IDX_W-1:0];
   end

   // trigger and sequence events
   always_comb begin
      trig_edge = ctrl2_reg[B_TRIG_EN] && !ctrl2_reg[B_TRIG_LEVEL] && ext_trig_i && !trig_d_reg;
      trig_start = ctrl2_reg[B_TRIG_EN] && !running && !wr_ctrl5 && !wr_abort
                   && (ctrl2_reg[B_TRIG_LEVEL] ? ext_trig_i : trig_edge);
      trig_ovr = trig_edge && running;
      start = wr_ctrl5 || trig_start;
      // a conversion finishing under an abort or restart is dropped
      conv_ok = running && conv_done_i && !wr_abort && !wr_ctrl5;
      seq_end = conv_ok && pos_reg == last_pos;
   end

   // control and mask registers
   always_comb begin
      ctrl2_next = ctrl2_reg;
      ctrl3_next = ctrl3_reg;
      ctrl4_next = ctrl4_reg;
      ctrl5_next = ctrl5_reg;
      test_next = test_reg;
      mask_next = mask_reg;
      if (wr_i) begin
         case (addr_i)
            OFS_CTRL_TWO: ctrl2_next = wdata_i;
            OFS_CTRL_THREE: ctrl3_next = wdata_i;
            OFS_CTRL_FOUR: ctrl4_next = wdata_i;
            OFS_SEQ_START: ctrl5_next = wdata_i;
            OFS_IRQ_MASK: mask_next = wdata_i;
            OFS_TEST_ZERO: begin
               if (special_mode_i) begin
                  test_next = wdata_i;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ctrl2_reg <= RST_BYTE;
         ctrl3_reg <= RST_BYTE;
         ctrl4_reg <= RST_BYTE;
         ctrl5_reg <= RST_BYTE;
         test_reg <= RST_BYTE;
         mask_reg <= RST_BYTE;
      end else begin
         ctrl2_reg <= ctrl2_next;
         ctrl3_reg <= ctrl3_next;
         ctrl4_reg <= ctrl4_next;
         ctrl5_reg <= ctrl5_next;
         test_reg <= test_next;
         mask_reg <= mask_next;
      end
   end

   // sequencer: state, conversion counter, position and channel
   always_comb begin
      state_next = state_reg;
      cc_next = cc_reg;
      pos_next = pos_reg;
      chan_next = chan_reg;
      trig_d_next = ext_trig_i;
      if (wr_abort) begin
         state_next = ST_IDLE;
         cc_next = IDX_ZERO;
         pos_next = IDX_ZERO;
      end else if (start) begin
         state_next = ST_RUN;
         pos_next = IDX_ZERO;
         chan_next = code;
         // a trigger start in FIFO mode keeps the counter running on
         if (wr_ctrl5 || !fifo_mode) begin
            cc_next = IDX_ZERO;
         end
      end else if (conv_ok) begin
         cc_next = next_idx(cc_reg);
         pos_next = next_idx(pos_reg);
         if (ctrl5_reg[B_MULTI_CHANNEL_SEL]) begin
            chan_next = next_idx(chan_reg);
         end
         if (seq_end) begin
            pos_next = IDX_ZERO;
            chan_next = code;
            if (!fifo_mode) begin
               cc_next = IDX_ZERO;
            end
            if (!ctrl5_reg[B_SCAN]) begin
               state_next = ST_IDLE;
            end
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state_reg <= ST_IDLE;
         cc_reg <= IDX_ZERO;
         pos_reg <= IDX_ZERO;
         chan_reg <= IDX_ZERO;
         trig_d_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cc_reg <= cc_next;
         pos_reg <= pos_next;
         chan_reg <= chan_next;
         trig_d_reg <= trig_d_next;
      end
   end

   // result path wiring
   always_comb begin
      rp.raw = conv_data_i;
      rp.res8 = ctrl4_reg[B_RES8];
      rp.rjust = ctrl5_reg[B_RJUST];
      rp.sgn = ctrl5_reg[B_SIGNED];
      rp.wr = conv_ok;
      rp.wr_idx = cc_reg;
      rp.clr_all = wr_ctrl5;
      rp.rd_idx = addr_i[IDX_W:1];
      // without fast clear a done-flags read must come first
      rp.rd_clr = res_rd && (fast_clr || armed_reg);
   end

   // status flags; every set wins over a clear in the same cycle
   always_comb begin
      scf_next = seq_end
                 || (scf_reg && !((wr_status && wdata_i[B_SCF]) || wr_ctrl5
                                  || (fast_clr && res_rd)));
      trigger_overrun_flag_next = trig_ovr
                   || (trigger_overrun_flag_reg && !((wr_status && wdata_i[B_TRIGGER_OVERRUN_FLAG]) || wr_abort
                                      || wr_ctrl5));
      result_overrun_flag_next = rp.ovr
                   || (result_overrun_flag_reg && !((wr_status && wdata_i[B_RESULT_OVERRUN_FLAG]) || start));
      armed_next = (rd_i && addr_i == OFS_DONE_FLAGS) || (armed_reg && !res_rd);
      irqs_next = irqs_reg;
      if (wr_irqs) begin
         irqs_next = irqs_reg & ~wdata_i;
      end
      irqs_next[B_IRQ_SEQ] = irqs_next[B_IRQ_SEQ] | seq_end;
      irqs_next[B_IRQ_TRIG] = irqs_next[B_IRQ_TRIG] | trig_ovr;
      irqs_next[B_IRQ_OVR] = irqs_next[B_IRQ_OVR] | rp.ovr;
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         scf_reg <= 1'b0;
         trigger_overrun_flag_reg <= 1'b0;
         result_overrun_flag_reg <= 1'b0;
         armed_reg <= 1'b0;
         irqs_reg <= RST_BYTE;
      end else begin
         scf_reg <= scf_next;
         trigger_overrun_flag_reg <= trigger_overrun_flag_next;
         result_overrun_flag_reg <= result_overrun_flag_next;
         armed_reg <= armed_next;
         irqs_reg <= irqs_next;
      end
   end

   // read data, held only in the cycle after the strobe
   always_comb begin
      status_val = RST_BYTE;
      status_val[B_SCF] = scf_reg;
      status_val[B_TRIGGER_OVERRUN_FLAG] = trigger_overrun_flag_reg;
      status_val[B_RESULT_OVERRUN_FLAG] = result_overrun_flag_reg;
      status_val[IDX_W-1:0] = cc_reg;
      rdata_next = RST_BYTE;
      if (rd_i) begin
         if (is_result(addr_i)) begin
            rdata_next = addr_i[0] ? rp.rd_data[DATA_W-1:0] : rp.rd_data[RES_W-1:DATA_W];
         end else begin
            case (addr_i)
               OFS_CTRL_TWO: rdata_next = ctrl2_reg;
               OFS_CTRL_THREE: rdata_next = ctrl3_reg;
               OFS_CTRL_FOUR: rdata_next = ctrl4_reg;
               OFS_SEQ_START: rdata_next = ctrl5_reg;
               OFS_STATUS_ZERO: rdata_next = status_val;
               // contents carry no meaning to software
               OFS_TEST_ZERO: rdata_next = test_reg;
               OFS_DONE_FLAGS: rdata_next = rp.done_flags;
               OFS_IRQ_STATUS: rdata_next = irqs_reg;
               OFS_IRQ_MASK: rdata_next = mask_reg;
               default: rdata_next = RST_BYTE;
            endcase
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rdata_reg <= RST_BYTE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_o = rdata_reg;
   assign conv_req_o = running;
   assign channel_o = chan_reg;
   assign irq_o = |(irqs_reg & mask_reg);

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   seq_flag_set_a: assert property (seq_end |=> scf_reg)
      else $error("sequence done flag not set after sequence end");
   seq_flag_clr_a: assert property (wr_ctrl5 && !seq_end |=> !scf_reg)
      else $error("sequence done flag survived a start write");
   trig_ovr_set_a: assert property (trig_ovr |=> trigger_overrun_flag_reg ##1 (trigger_overrun_flag_reg || wr_i || $past(wr_i)))
      else $error("trigger overrun not flagged");
   trig_ovr_clr_a: assert property (wr_abort && !trig_ovr |=> !trigger_overrun_flag_reg)
      else $error("trigger overrun survived an abort");
   res_ovr_set_a: assert property (rp.wr && rp.done_flags[rp.wr_idx] |=> ##1 result_overrun_flag_reg)
      else $error("result overrun not flagged two cycles after overwrite");
   res_ovr_clr_a: assert property (start && !rp.ovr |=> !result_overrun_flag_reg)
      else $error("result overrun survived a start");
   count_hold_a: assert property (wr_status && !conv_ok && !start && !wr_abort |=> $stable(cc_reg))
      else $error("status write moved the counter");
   count_end_a: assert property (seq_end && !fifo_mode |=> cc_reg == IDX_ZERO)
      else $error("counter not zero after non-FIFO sequence");
   count_step_a: assert property (conv_ok && fifo_mode |=> cc_reg == $past(cc_reg) + 3'h1)
      else $error("counter did not step and wrap");
   count_abort_a: assert property (wr_abort || wr_ctrl5 |=> cc_reg == IDX_ZERO)
      else $error("counter not cleared by control write");
   test_lock_a: assert property (wr_i && addr_i == OFS_TEST_ZERO && !special_mode_i |=> $stable(test_reg))
      else $error("test register written outside special mode");
   sign_bit_a: assert property (rp.sgn && !rp.rjust |-> rp.fmt[RES_W-1] == !conv_data_i[RAW_W-1])
      else $error("signed result top bit not inverted");
   right_just_a: assert property (rp.rjust |-> rp.fmt[RES_W-1:RAW_W] == 6'h00)
      else $error("right justified result has upper bits set");
   chan_step_a: assert property (conv_ok && !seq_end && ctrl5_reg[B_MULTI_CHANNEL_SEL]
                                 |=> channel_o == $past(chan_reg) + 3'h1)
      else $error("channel code did not advance");
endmodule

// ---- core/result_bank.sv ----
// eight result registers with their conversion done flags and overrun detect
`timescale 1ns/1ns
module result_bank
   import adc_fmt_pkg::*;
(
   input wire logic mclk_i, // module clock
   input wire logic sys_rst_i, // synchronous reset, high
   result_path_if.bank rp // write, clear and read side
);
   logic [RES_W-1:0] data_reg [NUM_RES];
   logic [RES_W-1:0] data_next [NUM_RES];
   logic [NUM_RES-1:0] ccf_reg, ccf_next;
   logic ovr_reg, ovr_next;

   always_comb begin
      data_next = data_reg;
      ccf_next = ccf_reg;
      ovr_next = 1'b0;
      if (rp.clr_all) begin
         ccf_next = '0;
      end
      if (rp.rd_clr) begin
         ccf_next[rp.rd_idx] = 1'b0;
      end
      // a new result wins over a clear of its own flag in the same cycle
      if (rp.wr) begin
         data_next[rp.wr_idx] = rp.fmt;
         ccf_next[rp.wr_idx] = 1'b1;
         ovr_next = ccf_reg[rp.wr_idx];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < NUM_RES; i++) begin
            data_reg[i] <= '0;
         end
         ccf_reg <= '0;
         ovr_reg <= 1'b0;
      end else begin
         data_reg <= data_next;
         ccf_reg <= ccf_next;
         ovr_reg <= ovr_next;
      end
   end

   assign rp.rd_data = data_reg[rp.rd_idx];
   assign rp.done_flags = ccf_reg;
   assign rp.ovr = ovr_reg;
endmodule

// ---- core/result_formatter.sv ----
// maps a raw conversion code onto the 16-bit result bus layout
`timescale 1ns/1ns
module result_formatter
   import adc_fmt_pkg::*;
(
   result_path_if.fmt_side rp // raw code in, formatted word out
);
   logic [DATA_W-1:0] r8;
   logic [RES_W-1:0] v;
   always_comb begin
      // eight-bit results are the top bits of the raw code
      r8 = rp.raw[RAW_W-1 -: DATA_W];
      if (rp.rjust) begin
         // sign select is ignored here: two's complement needs the top bus bit
         v = rp.res8 ? {8'h00, r8} : {6'h00, rp.raw};
      end else begin
         v = rp.res8 ? {r8, 8'h00} : {rp.raw, 6'h00};
         if (rp.sgn) begin
            v[RES_W-1] = ~v[RES_W-1];
         end
      end
      rp.fmt = v;
   end
endmodule

// ---- core/result_path_if.sv ----
// signals between the sequencer, the result formatter and the result bank
`timescale 1ns/1ns
interface result_path_if;
   logic [9:0] raw;
   logic res8;
   logic rjust;
   logic sgn;
   logic [15:0] fmt;
   logic wr;
   logic [2:0] wr_idx;
   logic clr_all;
   logic rd_clr;
   logic [2:0] rd_idx;
   logic [15:0] rd_data;
   logic [7:0] done_flags;
   logic ovr;
   modport ctrl(output raw, res8, rjust, sgn, wr, wr_idx, clr_all, rd_clr, rd_idx,
                input fmt, rd_data, done_flags, ovr);
   modport fmt_side(input raw, res8, rjust, sgn, output fmt);
   modport bank(input fmt, wr, wr_idx, clr_all, rd_clr, rd_idx, output rd_data, done_flags, ovr);
endinterface

// ---- verification/adc_result_format_status_bench.sv ----
// self-checking bench for the converter result formatting and status block
`timescale 1ns/1ns
module adc_result_format_status_bench;
   import adc_fmt_pkg::*;
   logic mclk_i, sys_rst_i, wr_i, rd_i, special_mode_i, ext_trig_i, conv_done_i, conv_req_o, irq_o;
   logic [4:0] addr_i;
   logic [7:0] wdata_i, rdata_o, rb;
   logic [9:0] conv_data_i, base;
   logic [2:0] channel_o;
   logic [15:0] w;
   int err_total, comparisons, cycles;

   adc_result_format_status dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .special_mode_i(special_mode_i), .ext_trig_i(ext_trig_i),
      .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .conv_req_o(conv_req_o), .channel_o(channel_o),
      .irq_o(irq_o));
   conv_core_model core (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .conv_req_i(conv_req_o), .gap_i(4'h3),
      .base_i(base), .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));

   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end

   task automatic wrap_up();
      $display("mismatches %0d of %0d comparisons", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // the whole run needs a few hundred cycles; this ceiling only catches a hang
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         wrap_up();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
   endtask

   task automatic chk_rd(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk({8'h00, d}, {8'h00, exp});
   endtask

   // both bytes of one result word, high byte at the even offset
   task automatic rd_res(input logic [2:0] i, output logic [15:0] v);
      logic [7:0] h, l;
      rd(OFS_RESULT_BASE + {1'b0, i, 1'b0}, h);
      rd(OFS_RESULT_BASE + {1'b0, i, 1'b1}, l);
      v = {h, l};
   endtask

   task automatic trig_pulse();
      @(posedge mclk_i);
      ext_trig_i <= 1'b1;
      @(posedge mclk_i);
      ext_trig_i <= 1'b0;
   endtask

   // follows one sequence and checks the analog input at every finished conversion
   task automatic run_seq(input logic [2:0] ch0, input logic multi_channel_sel, input int n);
      int k, got;
      logic [2:0] e;
      k = 0;
      got = 0;
      while (conv_req_o !== 1'b1 && k < 20) begin
         @(posedge mclk_i);
         k++;
      end
      // looked at mid-cycle, where the core's pulse and the channel are settled
      while (conv_req_o === 1'b1 && k < 300) begin
         @(negedge mclk_i);
         k++;
         if (conv_done_i === 1'b1 && conv_req_o === 1'b1) begin
            e = ch0 + (multi_channel_sel ? got[2:0] : 3'h0);
            chk({13'h0, channel_o}, {13'h0, e});
            got++;
         end
      end
      chk(got[15:0], n[15:0]);
      #1;
   endtask

   function automatic logic [15:0] fmt_exp(input logic r8, input logic rj, input logic sg, input logic [9:0] raw);
      logic [15:0] v;
      if (r8) begin
         v = rj ? {8'h00, raw[9:2]} : {raw[9:2], 8'h00};
      end else begin
         v = rj ? {6'h00, raw} : {raw, 6'h00};
      end
      // right justified words never carry a sign
      if (sg && !rj) begin
         v[15] = ~v[15];
      end
      return v;
   endfunction

   initial begin
      logic r8, rj, sg;
      int c;
      err_total = 0;
      comparisons = 0;
      cycles = 0;
      sys_rst_i = 1'b1;
      wr_i = 1'b0;
      rd_i = 1'b0;
      addr_i = 5'h00;
      wdata_i = 8'h00;
      special_mode_i = 1'b0;
      ext_trig_i = 1'b0;
      base = 10'h000;
      repeat (10) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      #1;
      chk({12'h0, conv_req_o, irq_o, rdata_o[0], |channel_o}, 16'h0000);
      chk_rd(OFS_STATUS_ZERO, 8'h00);
      // every format at full scale and midscale, channel codes 0 to 7 on the way
      for (int i = 0; i < 12; i++) begin
         c = i / 2;
         r8 = (c < 3);
         rj = (c % 3 == 2);
         sg = (c % 3 != 0);
         base = i[0] ? 10'h200 : 10'h3FF;
         wr(OFS_CTRL_FOUR, {r8, 7'h00});
         wr(OFS_CTRL_THREE, 8'h08);
         wr(OFS_SEQ_START, {rj, sg, 3'h0, i[2:0]});
         run_seq(i[2:0], 1'b0, 1);
         chk_rd(OFS_STATUS_ZERO, 8'h80);
         rd_res(3'h0, w);
         chk(w, fmt_exp(r8, rj, sg, base));
      end
      // eight-long multi-channel sweep wrapping from input seven to zero
      base = 10'h155;
      wr(OFS_CTRL_FOUR, 8'h00);
      wr(OFS_CTRL_THREE, 8'h00);
      wr(OFS_SEQ_START, 8'h93);
      run_seq(3'h3, 1'b1, 8);
      chk_rd(OFS_STATUS_ZERO, 8'h80);
      for (int i = 0; i < 8; i++) begin
         rd_res(i[2:0], w);
         chk(w, {6'h00, base + i[9:0]});
      end
      // interrupt: raised, masked, unmasked, cleared; fast clear on a result read
      wr(OFS_IRQ_STATUS, 8'h07);
      wr(OFS_IRQ_MASK, 8'h00);
      chk({15'h0, irq_o}, 16'h0000);
      wr(OFS_CTRL_TWO, 8'h40);
      wr(OFS_CTRL_THREE, 8'h08);
      wr(OFS_SEQ_START, 8'h80);
      run_seq(3'h0, 1'b0, 1);
      chk_rd(OFS_IRQ_STATUS, 8'h01);
      chk({15'h0, irq_o}, 16'h0000);
      wr(OFS_IRQ_MASK, 8'h01);
      chk({15'h0, irq_o}, 16'h0001);
      chk_rd(OFS_RESULT_BASE + 5'h01, base[7:0]);
      chk_rd(OFS_STATUS_ZERO, 8'h00);
      wr(OFS_IRQ_STATUS, 8'h01);
      chk({15'h0, irq_o}, 16'h0000);
      // FIFO mode: counter carried over, trigger overrun, wrap and result overrun
      wr(OFS_CTRL_TWO, 8'h04);
      wr(OFS_CTRL_THREE, 8'h1C);
      wr(OFS_SEQ_START, 8'h00);
      run_seq(3'h0, 1'b0, 3);
      chk_rd(OFS_STATUS_ZERO, 8'h83);
      trig_pulse();
      trig_pulse();
      run_seq(3'h0, 1'b0, 3);
      chk_rd(OFS_STATUS_ZERO, 8'hA6);
      trig_pulse();
      run_seq(3'h0, 1'b0, 3);
      chk_rd(OFS_STATUS_ZERO, 8'hB1);
      chk_rd(OFS_IRQ_STATUS, 8'h07);
      wr(OFS_STATUS_ZERO, 8'h17);
      chk_rd(OFS_STATUS_ZERO, 8'hA1);
      wr(OFS_CTRL_FOUR, 8'h00);
      chk_rd(OFS_STATUS_ZERO, 8'h80);
      wr(OFS_STATUS_ZERO, 8'h80);
      chk_rd(OFS_STATUS_ZERO, 8'h00);
      // continuous scan on one slot: the done and overrun flags come back after a clear
      wr(OFS_CTRL_THREE, 8'h08);
      wr(OFS_SEQ_START, 8'h20);
      repeat (12) @(posedge mclk_i);
      wr(OFS_STATUS_ZERO, 8'h90);
      repeat (6) @(posedge mclk_i);
      chk_rd(OFS_STATUS_ZERO, 8'h90);
      chk({15'h0, conv_req_o}, 16'h0001);
      wr(OFS_CTRL_TWO, 8'h00);
      chk({15'h0, conv_req_o}, 16'h0000);
      // without fast clear a result read clears its done flag only after a done-flags read
      chk_rd(OFS_DONE_FLAGS, 8'h01);
      rd(OFS_RESULT_BASE, rb);
      chk_rd(OFS_DONE_FLAGS, 8'h00);
      // level trigger: a fresh rising edge during a sequence is no overrun
      wr(OFS_STATUS_ZERO, 8'hB0);
      wr(OFS_CTRL_TWO, 8'h0C);
      trig_pulse();
      @(posedge mclk_i);
      ext_trig_i <= 1'b1;
      repeat (20) @(posedge mclk_i);
      rd(OFS_STATUS_ZERO, rb);
      chk({8'h00, rb & 8'hA0}, 16'h0080);
      @(posedge mclk_i);
      ext_trig_i <= 1'b0;
      wr(OFS_CTRL_TWO, 8'h00);
      // test register only takes writes in special mode; unmapped offsets stay silent
      wr(OFS_TEST_ZERO, 8'hA5);
      chk_rd(OFS_TEST_ZERO, 8'h00);
      @(posedge mclk_i);
      special_mode_i <= 1'b1;
      wr(OFS_TEST_ZERO, 8'h5A);
      chk_rd(OFS_TEST_ZERO, 8'h5A);
      @(posedge mclk_i);
      special_mode_i <= 1'b0;
      wr(5'h0E, 8'hFF);
      chk_rd(5'h0E, 8'h00);
      wrap_up();
   end
endmodule

// ---- verification/conv_core_model.sv ----
// behavioural model of the analog conversion core behind the sequencer
`timescale 1ns/1ns
module conv_core_model (
   input wire logic mclk_i, // module clock
   input wire logic sys_rst_i, // synchronous reset, high
   input wire logic conv_req_i, // sequence in progress
   input wire logic [3:0] gap_i, // idle cycles before each result
   input wire logic [9:0] base_i, // code of the first conversion
   output logic conv_done_o, // one-cycle result pulse
   output logic [9:0] conv_data_o // raw code, valid with conv_done_o
);
   logic [3:0] wait_reg;
   logic [9:0] num_reg;

   // each conversion returns base plus its position, so result slots can be told apart
   // outside the pulse the data lines flip every cycle: a stale code must never be taken
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || !conv_req_i) begin
         wait_reg <= 4'h0;
         num_reg <= 10'h000;
         conv_done_o <= 1'b0;
         // start from a known code so the data lines never carry unknowns into the formatter
         conv_data_o <= sys_rst_i ? 10'h000 : ~conv_data_o;
      end else if (wait_reg == gap_i) begin
         wait_reg <= 4'h0;
         num_reg <= num_reg + 10'h001;
         conv_done_o <= 1'b1;
         conv_data_o <= base_i + num_reg;
      end else begin
         wait_reg <= wait_reg + 4'h1;
         conv_done_o <= 1'b0;
         conv_data_o <= ~conv_data_o;
      end
   end
endmodule
